/* src/mcm_pkg.sv */
// Package for the core memory-map block: special-register addresses, field positions, resets.
// Assumes a single core clock and an 8-bit direct/indirect data access port from the core.
package mcm_pkg;
	localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
	localparam logic [7:0] PSW_ADDR = 8'hd0;
	localparam logic [7:0] ACC_ADDR = 8'he0;
	localparam logic [7:0] SP_ADDR = 8'h81;
	localparam logic [7:0] DPL_ADDR = 8'h82;
	localparam logic [7:0] DPH_ADDR = 8'h83;
	localparam logic [7:0] DPP_ADDR = 8'h84;
	localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
	localparam logic [7:0] PSW_RESET = 8'h00;
	localparam logic [7:0] SP_RESET = 8'h07;
	localparam logic [7:0] DP_RESET = 8'h00;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] LOW_RAM_TOP = 8'h7f;
	localparam logic [7:0] BIT_AREA_BASE = 8'h20;
	localparam logic [7:0] SFR_BIT_BASE = 8'h80;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam int PSW_CARRY = 7;
	localparam int PSW_HALF_CARRY = 6;
	localparam int PSW_USER_A = 5;
	localparam int PSW_BANK_HI = 4;
	localparam int PSW_BANK_LO = 3;
	localparam int PSW_OVERFLOW = 2;
	localparam int PSW_USER_B = 1;
	localparam int PSW_PARITY = 0;
	localparam int POWER_CONTROL_BAUD_DOUBLE = 7;
	localparam int POWER_CONTROL_SERIAL_WAKE = 6;
	localparam int POWER_CONTROL_IRQ0_WAKE = 5;
	localparam int POWER_CONTROL_STROBE_OFF = 4;
	localparam int POWER_CONTROL_GEN_B = 3;
	localparam int POWER_CONTROL_GEN_A = 2;
	localparam int POWER_CONTROL_POWER_DOWN = 1;
	localparam int POWER_CONTROL_IDLE = 0;
	localparam int STROBE_PERIOD = 6;
	localparam int INT_CODE_BYTES = 8192;
endpackage : mcm_pkg

/* src/mcm_ram_if.sv */
// Interface between the map decoder and the internal 256-byte data RAM.
// Assumes both ends on the core clock.
`timescale 1ns/1ps
interface mcm_ram_if;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctrl (output we, output addr, output wdata, input rdata);
	modport mem (input we, input addr, input wdata, output rdata);
endinterface : mcm_ram_if

/* src/mcm_ram.sv */
// Internal 256-byte data RAM in flip-flops, combinational read.
// Assumes the decoder has resolved bank, bit and indirect addressing already.
`timescale 1ns/1ps
module mcm_ram #(
	parameter int DEPTH = 256
) (
	input wire logic clock, // Core clock
	mcm_ram_if.mem bus // RAM port
);
	logic [7:0] mem_r [DEPTH];

	// No reset: RAM contents are undefined after power-up
	always_ff @(posedge clock) begin
		if (bus.we) begin
			mem_r[bus.addr] <= bus.wdata;
		end
	end

	assign bus.rdata = mem_r[bus.addr];
endmodule : mcm_ram

/* src/mcm_core_map.sv */
// Core memory map: code select strap, internal RAM decode, working banks, bit area,
// stack pointer, three-byte data pointer, status word and power control register.
// Assumes the core issues one access per cycle; RAM and registers answer combinationally.
`timescale 1ns/1ps
module mcm_core_map
	import mcm_pkg::*;
(
	input wire logic clock, // Core clock, 50 MHz
	input wire logic reset, // Async reset, active high
	input wire logic ext_code_select_n, // Code-select strap pin, low selects external
	input wire logic [15:0] fetch_addr, // Code fetch address from core
	input wire logic acc_en, // Byte access strobe
	input wire logic acc_we, // Byte access is a write
	input wire logic acc_indirect, // Byte access uses indirect mode
	input wire logic acc_work_reg, // Address is a working register index 0..7
	input wire logic [7:0] acc_addr, // Byte address or register index
	input wire logic [7:0] acc_wdata, // Byte write data
	output logic [7:0] acc_rdata, // Byte read data
	input wire logic bit_en, // Bit access strobe
	input wire logic bit_we, // Bit access is a write
	input wire logic [7:0] bit_addr, // Bit address
	input wire logic bit_wdata, // Bit write value
	output logic bit_rdata, // Bit read value
	input wire logic stack_push, // Push or call: pre-increment and write
	input wire logic stack_pop, // Pop or return: read then decrement
	input wire logic [7:0] stack_wdata, // Byte pushed
	input wire logic data_pointer_pair_inc, // Increment data pointer pair with carry to page
	input wire logic flags_we, // Core updates arithmetic flags
	input wire logic [7:0] flags_wdata, // New carry, half, overflow in their positions
	output logic code_external, // Registered: fetches go to external program space
	output logic fetch_internal, // Fetch hits internal code memory
	output logic [23:0] ext_data_addr, // Registered: page, high, low data pointer
	output logic [7:0] stack_pointer, // Registered stack pointer
	output logic [1:0] bank_select, // Registered active bank
	output logic [7:0] power_control, // Registered power control
	output logic [7:0] processor_status_word, // Registered status word
	output logic addr_latch_strobe // Periodic address-latch strobe
);
	logic [7:0] accumulator_r;
	logic [7:0] psw_r;
	logic [7:0] psw_nxt;
	logic [7:0] power_control_r;
	logic [7:0] sp_r;
	logic [7:0] dpl_r;
	logic [7:0] dph_r;
	logic [7:0] dpp_r;
	logic strap_meta_r;
	logic strap_sync_r;
	logic strap_taken_r;
	logic [1:0] strap_wait_r;
	logic code_ext_r;
	logic [2:0] strobe_cnt_r;
	logic strobe_r;
	logic [7:0] bit_byte;
	logic [2:0] bit_pos;
	logic bit_in_ram;
	logic [7:0] sfr_byte;
	logic sfr_hit;
	logic [7:0] bit_cur;
	logic [7:0] bit_new;
	logic direct_sfr;
	logic [7:0] ram_byte_addr;
	mcm_ram_if ram ();

	function automatic logic [7:0] work_reg_addr(input logic [1:0] bank, input logic [2:0] idx);
		return {3'h0, bank, idx};
	endfunction : work_reg_addr

	function automatic logic sfr_present(input logic [7:0] a);
		return a inside {ACC_ADDR, PSW_ADDR, POWER_CONTROL_ADDR, SP_ADDR, DPL_ADDR, DPH_ADDR, DPP_ADDR};
	endfunction : sfr_present

	// Reads live registers, so only called from combinational processes
	function automatic logic [7:0] sfr_value(input logic [7:0] a);
		logic [7:0] v;
		unique case (a)
			ACC_ADDR: v = accumulator_r;
			PSW_ADDR: v = psw_r;
			POWER_CONTROL_ADDR: v = power_control_r;
			SP_ADDR: v = sp_r;
			DPL_ADDR: v = dpl_r;
			DPH_ADDR: v = dph_r;
			DPP_ADDR: v = dpp_r;
			default: v = UNMAPPED_READ;
		endcase
		return v;
	endfunction : sfr_value

	// Strap synchroniser; the sample is frozen once after reset release
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			strap_meta_r <= 1'b0;
			strap_sync_r <= 1'b0;
		end else begin
			strap_meta_r <= ext_code_select_n;
			strap_sync_r <= strap_meta_r;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			strap_wait_r <= 2'h0;
			strap_taken_r <= 1'b0;
			code_ext_r <= 1'b0;
		end else if (!strap_taken_r) begin
			// Two edges first, so the synchroniser holds the pin level
			if (strap_wait_r == 2'h2) begin
				strap_taken_r <= 1'b1;
				code_ext_r <= !strap_sync_r;
			end else begin
				strap_wait_r <= strap_wait_r + 2'h1;
			end
		end
	end

	assign code_external = code_ext_r;
	assign fetch_internal = !code_ext_r && (32'(fetch_addr) < INT_CODE_BYTES);

	// Bit address decode: low half into RAM bit area, high half into special registers
	assign bit_pos = bit_addr[2:0];
	assign bit_in_ram = !bit_addr[7];
	assign bit_byte = bit_in_ram ? (BIT_AREA_BASE + {4'h0, bit_addr[6:3]})
		: {bit_addr[7:3], 3'h0};
	assign sfr_hit = sfr_present(bit_byte);
	always_comb begin
		sfr_byte = sfr_value(bit_byte);
	end
	assign direct_sfr = acc_addr > LOW_RAM_TOP && !acc_indirect && !acc_work_reg;

	always_comb begin
		bit_cur = bit_in_ram ? ram.rdata : sfr_byte;
		bit_new = bit_cur;
		bit_new[bit_pos] = bit_wdata;
	end
	assign bit_rdata = bit_cur[bit_pos];

	// RAM port: one user per cycle, stack first, then bit, then byte access
	always_comb begin
		ram_byte_addr = acc_work_reg ? work_reg_addr(psw_r[PSW_BANK_HI:PSW_BANK_LO], acc_addr[2:0])
			: acc_addr;
		ram.we = 1'b0;
		ram.wdata = acc_wdata;
		ram.addr = ram_byte_addr;
		if (stack_push) begin
			ram.addr = sp_r + 8'h01;
			ram.wdata = stack_wdata;
			ram.we = 1'b1;
		end else if (stack_pop) begin
			ram.addr = sp_r;
		end else if (bit_en) begin
			ram.addr = bit_byte;
			ram.wdata = bit_new;
			ram.we = bit_we && bit_in_ram;
		end else if (acc_en) begin
			ram.we = acc_we && !direct_sfr;
		end
	end

	always_comb begin
		if (stack_pop) begin
			acc_rdata = ram.rdata;
		end else begin
			acc_rdata = direct_sfr ? sfr_value(acc_addr) : ram.rdata;
		end
	end

	mcm_ram #(.DEPTH(256)) u_ram (
		.clock(clock),
		.bus(ram.mem)
	);

	function automatic logic sfr_wr(input logic [7:0] a);
		return (acc_en && acc_we && direct_sfr && acc_addr == a && !stack_push && !stack_pop && !bit_en)
			|| (bit_en && bit_we && !bit_in_ram && bit_byte == a && sfr_hit && !stack_push && !stack_pop);
	endfunction : sfr_wr

	function automatic logic [7:0] sfr_wval(input logic [7:0] a);
		return (bit_en && bit_byte == a) ? bit_new : acc_wdata;
	endfunction : sfr_wval

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			accumulator_r <= ACC_RESET;
		end else if (sfr_wr(ACC_ADDR)) begin
			accumulator_r <= sfr_wval(ACC_ADDR);
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sp_r <= SP_RESET;
		end else if (stack_push) begin
			sp_r <= sp_r + 8'h01;
		end else if (stack_pop) begin
			sp_r <= sp_r - 8'h01;
		end else if (sfr_wr(SP_ADDR)) begin
			sp_r <= sfr_wval(SP_ADDR);
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			dpl_r <= DP_RESET;
			dph_r <= DP_RESET;
			dpp_r <= DP_RESET;
		end else if (data_pointer_pair_inc) begin
			{dpp_r, dph_r, dpl_r} <= {dpp_r, dph_r, dpl_r} + 24'h000001;
		end else begin
			if (sfr_wr(DPL_ADDR)) begin
				dpl_r <= sfr_wval(DPL_ADDR);
			end
			if (sfr_wr(DPH_ADDR)) begin
				dph_r <= sfr_wval(DPH_ADDR);
			end
			if (sfr_wr(DPP_ADDR)) begin
				dpp_r <= sfr_wval(DPP_ADDR);
			end
		end
	end
	assign ext_data_addr = {dpp_r, dph_r, dpl_r};
	assign stack_pointer = sp_r;

	// Parity is never stored from software; it always follows the accumulator
	always_comb begin
		psw_nxt = psw_r;
		if (sfr_wr(PSW_ADDR)) begin
			psw_nxt = sfr_wval(PSW_ADDR);
		end
		if (flags_we) begin
			psw_nxt[PSW_CARRY] = flags_wdata[PSW_CARRY];
			psw_nxt[PSW_HALF_CARRY] = flags_wdata[PSW_HALF_CARRY];
			psw_nxt[PSW_OVERFLOW] = flags_wdata[PSW_OVERFLOW];
		end
		psw_nxt[PSW_PARITY] = ^accumulator_r;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			psw_r <= PSW_RESET;
		end else begin
			psw_r <= psw_nxt;
		end
	end
	assign processor_status_word = psw_r;
	assign bank_select = psw_r[PSW_BANK_HI:PSW_BANK_LO];

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			power_control_r <= POWER_CONTROL_RESET;
		end else if (acc_en && acc_we && direct_sfr && acc_addr == POWER_CONTROL_ADDR && !stack_push
			&& !stack_pop && !bit_en) begin
			power_control_r <= acc_wdata; // Not bit-addressable
		end
	end
	assign power_control = power_control_r;

	// Strobe every six core clocks; held low while disabled
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			strobe_cnt_r <= 3'h0;
			strobe_r <= 1'b0;
		end else begin
			strobe_cnt_r <= (strobe_cnt_r == 3'(STROBE_PERIOD - 1)) ? 3'h0 : strobe_cnt_r + 3'h1;
			strobe_r <= (strobe_cnt_r == 3'h0) && !power_control_r[POWER_CONTROL_STROBE_OFF];
		end
	end
	assign addr_latch_strobe = strobe_r;
endmodule : mcm_core_map

/* tb/mcm_core_map_assertions.sv */
// Checker for the core memory map, watching top-level ports only.
// Assumes a bind onto mcm_core_map and one core clock domain.
`timescale 1ns/1ps
module mcm_core_map_assertions
	import mcm_pkg::*;
(
	input wire logic clock, // Core clock
	input wire logic reset, // Async reset
	input wire logic [15:0] fetch_addr, // Fetch address
	input wire logic data_pointer_pair_inc, // Pointer increment
	input wire logic flags_we, // Flag update
	input wire logic [7:0] flags_wdata, // Flag values
	input wire logic code_external, // Code source
	input wire logic fetch_internal, // Internal hit
	input wire logic [23:0] ext_data_addr, // Data pointer
	input wire logic [1:0] bank_select, // Active bank
	input wire logic [7:0] power_control, // Power control
	input wire logic [7:0] processor_status_word, // Status word
	input wire logic addr_latch_strobe // Strobe
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	property p_fetch; fetch_internal == (!code_external && fetch_addr < 16'h2000); endproperty
	a_fetch: assert property (p_fetch) else $error("fetch hit wrong");
	// Strap may only take effect just after a reset release
	property p_strap; !$stable(code_external) |-> $past(reset, 2) || $past(reset, 3)
		|| $past(reset, 4); endproperty
	a_strap: assert property (p_strap) else $error("code source moved");
	property p_bank; bank_select == processor_status_word[4:3]; endproperty
	a_bank: assert property (p_bank) else $error("bank select wrong");
	property p_off; power_control[4] && $past(power_control[4]) |-> !addr_latch_strobe;
	endproperty
	a_off: assert property (p_off) else $error("strobe while off");
	property p_gap; addr_latch_strobe |=> !addr_latch_strobe [*5]; endproperty
	a_gap: assert property (p_gap) else $error("strobe too often");
	property p_data_pointer_pair; data_pointer_pair_inc |=> ext_data_addr == $past(ext_data_addr) + 24'h1; endproperty
	a_data_pointer_pair: assert property (p_data_pointer_pair) else $error("pointer step wrong");
	property p_flags; flags_we |=> processor_status_word[7:6] == $past(flags_wdata[7:6])
		&& processor_status_word[2] == $past(flags_wdata[2]); endproperty
	a_flags: assert property (p_flags) else $error("flags not taken");
	property p_rst; $past(reset) |-> power_control == POWER_CONTROL_RESET
		&& processor_status_word == PSW_RESET && ext_data_addr == 24'h0; endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule : mcm_core_map_assertions

/* tb/mcm_core_model.sv */
// Core-side model: code-select strap pin and a sweeping fetch address.
// Assumes the bench picks the strap level; fetches advance every cycle.
`timescale 1ns/1ps
module mcm_core_model (
	input wire logic clock, // Core clock
	input wire logic strap_low, // Strap pulled low
	output logic ext_code_select_n, // Strap pin
	output logic [15:0] fetch_addr // Fetch address
);
	assign ext_code_select_n = !strap_low;
	initial fetch_addr = 16'h0000;
	// Large step so the 8K boundary is crossed often
	always @(posedge clock) fetch_addr <= #1 fetch_addr + 16'h0700;
endmodule : mcm_core_model

/* tb/mcm_core_map_tb.sv */
// Bench for the core memory map: byte, bit, stack and pointer accesses.
// Assumes the core-side model supplies strap and fetch address.
`timescale 1ns/1ps
module mcm_core_map_tb;
	import mcm_pkg::*;
	logic clock, reset, strap_low, acc_en, acc_we, acc_indirect, acc_work_reg;
	logic bit_en, bit_we, bit_wdata, stack_push, stack_pop, data_pointer_pair_inc, flags_we;
	logic [7:0] acc_addr, acc_wdata, bit_addr, stack_wdata, flags_wdata, q;
	logic ext_code_select_n, bit_rdata, code_external, fetch_internal, addr_latch_strobe;
	logic [15:0] fetch_addr;
	logic [23:0] ext_data_addr;
	logic [1:0] bank_select;
	logic [7:0] acc_rdata, power_control, processor_status_word, stack_pointer, rdata_q;
	logic bit_q;
	int errors, cmp_count, seen;
	mcm_core_model i_core (.clock, .strap_low, .ext_code_select_n, .fetch_addr);
	mcm_core_map i_dut (.clock, .reset, .ext_code_select_n, .fetch_addr, .acc_en, .acc_we,
		.acc_indirect, .acc_work_reg, .acc_addr, .acc_wdata, .acc_rdata, .bit_en, .bit_we,
		.bit_addr, .bit_wdata, .bit_rdata, .stack_push, .stack_pop, .stack_wdata, .data_pointer_pair_inc,
		.flags_we, .flags_wdata, .code_external, .fetch_internal, .ext_data_addr,
		.stack_pointer, .bank_select, .power_control, .processor_status_word,
		.addr_latch_strobe);
	initial begin
		clock = 0;
		forever #10 clock = ~clock;
	end
	// Read data taken at the access edge, before that edge updates anything
	always @(posedge clock) begin
		rdata_q <= acc_rdata;
		bit_q <= bit_rdata;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Idle cycle after each access so strobes never toggle within one step
	// No ones into reserved bits no reserved addresses
	task automatic acc(input logic we, ind, wk, input logic [7:0] a, d);
		acc_en = 1;
		acc_we = we;
		acc_indirect = ind;
		acc_work_reg = wk;
		acc_addr = a;
		acc_wdata = d;
		@(posedge clock);
		#1 q = rdata_q;
		acc_en = 0;
		tick(1);
	endtask : acc
	task automatic bt(input logic we, input logic [7:0] a, input logic d);
		bit_en = 1;
		bit_we = we;
		bit_addr = a;
		bit_wdata = d;
		@(posedge clock);
		#1 q = {7'h0, bit_q};
		bit_en = 0;
		tick(1);
	endtask : bt
	task automatic results;
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	initial begin
		{acc_en, acc_we, acc_indirect, acc_work_reg, bit_en, bit_we, bit_wdata} = '0;
		{stack_push, stack_pop, data_pointer_pair_inc, flags_we, strap_low} = '0;
		{acc_addr, acc_wdata, bit_addr, stack_wdata, flags_wdata} = '0;
		reset = 1;
		repeat (3) @(posedge clock);
		#1 reset = 0;
		tick(4);
		acc(0, 0, 0, POWER_CONTROL_ADDR, 0); chk("power_control", POWER_CONTROL_RESET, q);
		acc(0, 0, 0, PSW_ADDR, 0); chk("psw", PSW_RESET, q);
		acc(0, 0, 0, SP_ADDR, 0); chk("sp", SP_RESET, q);
		acc(0, 0, 0, 8'hf5, 0); chk("unmapped", UNMAPPED_READ, q);
		chk("code_ext", 0, code_external);
		chk("fetch_int", {23'h0, fetch_addr < 16'h2000}, fetch_internal);
		$display("test reset done");
		acc(1, 0, 0, POWER_CONTROL_ADDR, 8'hff); chk("power_control_rw", 8'hff, power_control);
		seen = 0;
		repeat (12) begin
			tick(1);
			seen += addr_latch_strobe;
		end
		chk("strobe_off", 0, seen);
		acc(1, 0, 0, POWER_CONTROL_ADDR, 8'h00);
		tick(1);
		seen = 0;
		repeat (6) begin
			tick(1);
			seen += addr_latch_strobe;
		end
		chk("strobe_on", 1, seen);
		$display("test strobe done");
		for (int b = 0; b < 4; b++) begin
			acc(1, 0, 0, PSW_ADDR, 8'(b << 3));
			acc(1, 0, 1, 8'h00, 8'(8'h10 + b));
			chk("bank", b, bank_select);
			acc(0, 0, 0, 8'(b * 8), 0); chk("reg0", 8'h10 + b, q);
		end
		acc(1, 0, 0, PSW_ADDR, 0);
		$display("test banks done");
		acc(1, 1, 0, 8'h87, 8'h5a);
		acc(0, 0, 0, POWER_CONTROL_ADDR, 0); chk("power_control_direct", 0, q);
		acc(0, 1, 0, 8'h87, 0); chk("upper_ram", 8'h5a, q);
		acc(1, 0, 0, 8'h40, 8'ha5);
		acc(0, 1, 0, 8'h40, 0); chk("low_ram", 8'ha5, q);
		$display("test modes done");
		acc(1, 0, 0, 8'h2f, 0);
		bt(1, 8'h7f, 1);
		acc(0, 0, 0, 8'h2f, 0); chk("bit_7f", 8'h80, q);
		bt(0, 8'h7f, 0); chk("bit_rd", 1, q);
		bt(1, 8'hd5, 1);
		acc(0, 0, 0, PSW_ADDR, 0); chk("psw_bit", 8'h20, q);
		acc(1, 0, 0, PSW_ADDR, 0);
		$display("test bits done");
		stack_wdata = 8'h3c;
		stack_push = 1;
		tick(1);
		stack_push = 0;
		tick(1);
		acc(0, 0, 0, SP_ADDR, 0); chk("sp_push", 8'h08, q);
		chk("sp_port", 8'h08, stack_pointer);
		acc(0, 0, 0, 8'h08, 0); chk("stack_top", 8'h3c, q);
		stack_pop = 1;
		@(posedge clock);
		#1 q = rdata_q;
		stack_pop = 0;
		chk("pop", 8'h3c, q);
		tick(1);
		acc(0, 0, 0, SP_ADDR, 0); chk("sp_pop", 8'h07, q);
		$display("test stack done");
		acc(1, 0, 0, DPP_ADDR, 8'h12);
		acc(1, 0, 0, DPH_ADDR, 8'hff);
		acc(1, 0, 0, DPL_ADDR, 8'hff);
		chk("dp", 24'h12ffff, ext_data_addr);
		data_pointer_pair_inc = 1;
		tick(1);
		data_pointer_pair_inc = 0;
		tick(1);
		chk("dp_inc", 24'h130000, ext_data_addr);
		$display("test pointer done");
		acc(1, 0, 0, ACC_ADDR, 8'h07);
		flags_wdata = 8'hff;
		flags_we = 1;
		tick(1);
		flags_we = 0;
		tick(1);
		acc(0, 0, 0, PSW_ADDR, 0); chk("psw_flags", 8'hc5, q);
		$display("test flags done");
		strap_low = 1;
		reset = 1;
		tick(2);
		reset = 0;
		tick(4);
		chk("code_ext_low", 1, code_external);
		chk("fetch_ext", 0, fetch_internal);
		strap_low = 0;
		tick(6);
		chk("strap_held", 1, code_external);
		$display("test strap done");
		results;
	end
	// Tests need about 125 cycles; this allows about 5000
	initial begin
		#100000;
		errors++;
		results;
	end
endmodule : mcm_core_map_tb
bind mcm_core_map mcm_core_map_assertions i_chk (.clock, .reset, .fetch_addr, .data_pointer_pair_inc,
	.flags_we, .flags_wdata, .code_external, .fetch_internal, .ext_data_addr, .bank_select,
	.power_control, .processor_status_word, .addr_latch_strobe);
